// ---- testbench/msa_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module msa_host_model (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_en,
  input wire logic i_slow,
  output logic o_rd_req
);
  int gap;
  // one-cycle read pulses, spaced so no read is left pending
  initial begin
    o_rd_req = 1'b0;
    gap = 0;
    forever begin
      @(negedge i_sys_clk);
      o_rd_req = gap == 0 && i_en && !i_reset;
      if (o_rd_req)
        gap = i_slow ? 8 : 2;
      else if (gap > 0)
        gap--;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/msa_scan_acq_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msa_defines.svh"
module msa_scan_acq_asserts import msa_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [7:0] i_din,
  input wire logic i_dout_port_wr,
  input wire logic [7:0] i_dout_port_val,
  input wire logic i_dout_line_wr,
  input wire logic [2:0] i_dout_line_sel,
  input wire logic i_dout_line_val,
  input wire logic i_rd_req,
  input wire logic [7:0] o_dout,
  input wire logic o_dout_en,
  input wire logic [7:0] o_din_port,
  input wire msa_rd_s o_rd,
  input wire logic o_running,
  input wire logic o_overrun,
  input wire logic o_overrun_evt
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_halted;
    o_overrun [*3];
  endsequence
  sequence s_settled;
    !$past(i_reset) && !$past(i_reset, 2);
  endsequence
  property p_dout_off;
    !o_dout_en |-> o_dout == 8'h00;
  endproperty
  a_dout_off: assert property (p_dout_off)
    else $error("outputs on while disabled");
  property p_port_wr;
    i_dout_port_wr |=> o_dout_en && o_dout == $past(i_dout_port_val);
  endproperty
  a_port_wr: assert property (p_port_wr)
    else $error("port write lost");
  property p_line_wr;
    i_dout_line_wr && !i_dout_port_wr
      |=> o_dout[$past(i_dout_line_sel)] == $past(i_dout_line_val);
  endproperty
  a_line_wr: assert property (p_line_wr)
    else $error("line write lost");
  property p_din;
    s_settled |-> o_din_port == $past(i_din, 2);
  endproperty
  a_din: assert property (p_din)
    else $error("input port mismatch");
  property p_rd_lat;
    o_rd.valid |-> $past(i_rd_req, 2);
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read word without request");
  property p_halt_rd;
    s_halted |-> !o_rd.valid;
  endproperty
  a_halt_rd: assert property (p_halt_rd)
    else $error("transfer after overrun");
  property p_evt;
    o_overrun_evt |=> o_overrun ##1 !o_running;
  endproperty
  a_evt: assert property (p_evt)
    else $error("overrun did not halt");
  property p_stop;
    i_stop && !i_start |-> ##2 !o_running;
  endproperty
  a_stop: assert property (p_stop)
    else $error("still running after stop");
endmodule
bind msa_scan_acq msa_scan_acq_asserts msa_scan_acq_asserts_inst (
  .i_sys_clk, .i_reset, .i_start, .i_stop, .i_din, .i_dout_port_wr,
  .i_dout_port_val, .i_dout_line_wr, .i_dout_line_sel, .i_dout_line_val,
  .i_rd_req, .o_dout, .o_dout_en, .o_din_port, .o_rd, .o_running,
  .o_overrun, .o_overrun_evt
);
`default_nettype wire

// ---- testbench/multichannel_scan_acquisition_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msa_defines.svh"
module multichannel_scan_acquisition_tb import msa_pkg::*;
;
  logic clk, rst, start, stop, trig, cjc, filt, pwr, lwr, lval, rd_en;
  logic slow, rd_req, dout_en, dline, filt_o, run, ovr, evt;
  logic [15:0] div;
  logic [2:0] bank, dsel, lsel;
  logic [48:0] en;
  logic [7:0] din, pval, dout, dport, e8;
  logic [8:0] fill;
  logic [31:0] seed;
  msa_chan_s ch [`MSA_NUM_CH_MAX];
  msa_rd_s rd;
  logic [31:0] exp_q [$];
  logic [31:0] got_q [$];
  int n_fail, samples_checked;

  msa_scan_acq #(.BASE_CYCLES(10), .TRIG_CYCLES(20)) msa_scan_acq_inst (
    .i_sys_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_start(start),
    .i_stop(stop), .i_ext_trig_en(trig), .i_clk_div(div),
    .i_bank_count(bank), .i_chan_en(en), .i_cjc_en(cjc),
    .i_filter_avg(filt), .i_chan(ch), .i_din(din), .i_din_line_sel(dsel),
    .i_dout_port_wr(pwr), .i_dout_port_val(pval), .i_dout_line_wr(lwr),
    .i_dout_line_sel(lsel), .i_dout_line_val(lval), .i_rd_req(rd_req),
    .o_dout(dout), .o_dout_en(dout_en), .o_din_port(dport),
    .o_din_line(dline), .o_filter_avg(filt_o), .o_rd(rd),
    .o_running(run), .o_overrun(ovr), .o_overrun_evt(evt), .o_fill(fill)
  );
  msa_host_model msa_host_model_inst (
    .i_sys_clk(clk), .i_reset(rst), .i_en(rd_en), .i_slow(slow),
    .o_rd_req(rd_req)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) if (rd.valid === 1'b1) got_q.push_back(rd.data);

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] flt(input logic [7:0] v);
    int e;
    e = 7;
    if (v == 8'h00) return 32'h0000_0000;
    while (!v[e]) e--;
    return {1'b0, 8'(`MSA_FLOAT_BIAS + e), 23'(32'(v) << (23 - e))};
  endfunction
  function automatic logic [31:0] exp_word(input msa_chan_s c);
    if (c.open_sensor) return `MSA_OPEN_WORD;
    if (c.above_range) return `MSA_ABOVE_WORD;
    if (c.below_range) return `MSA_BELOW_WORD;
    return c.value;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: %h vs %h", $time, g, x);
    end
  endtask
  task automatic chkb(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse_start();
    start = 1'b1;
    cyc(1);
    start = 1'b0;
  endtask
  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one continuous run, flags forcing sentinels or cjc words
  task automatic scan(input logic f, input logic s);
    int nai;
    bank = 3'(rnd() % 6 + 1);
    nai = 8 * int'(bank);
    en = 49'({rnd(), rnd()});
    en[nai] = 1'b1;
    cjc = ~f;
    slow = s;
    filt = seed[3];
    din = 8'(rnd());
    exp_q = {};
    got_q = {};
    for (int i = 0; i < nai; i++) begin
      ch[i] = {f && i % 4 == 1, f && i % 4 inside {1, 2},
               f && i % 4 inside {1, 3}, rnd(), rnd()};
      if (en[i]) exp_q.push_back(exp_word(ch[i]));
      if (en[i] && cjc) exp_q.push_back(ch[i].cjc);
    end
    exp_q.push_back(flt(din));
    pulse_start();
    cyc(2);
    chkb(run, 1'b1);
    chkb(filt_o, filt);
    cyc(1500);
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    for (int k = 0; k < 3000 && fill !== 9'h000; k++) cyc(1);
    chk(32'(fill), 32'h0000_0000);
    cyc(12);
    chk(32'(got_q.size()), 32'(3 * exp_q.size()));
    foreach (got_q[k]) chk(got_q[k], exp_q[k % exp_q.size()]);
  endtask

  initial begin
    seed = 32'h0000_767F;
    rst = 1'b1;
    {start, stop, trig, cjc, filt, pwr, lwr, lval, rd_en, slow} = '0;
    div = 16'h0028;
    bank = 3'h1;
    en = '0;
    din = 8'h00;
    pval = 8'h00;
    dsel = 3'h0;
    lsel = 3'h0;
    n_fail = 0;
    samples_checked = 0;
    foreach (ch[i]) ch[i] = '0;
    cyc(8);
    rst = 1'b0;
    chk(32'(dout), 32'h0000_0000);
    chkb(dout_en, 1'b0);
    for (int k = 0; k < 8; k++) begin
      pval = 8'(rnd());
      pwr = 1'b1;
      din = 8'(rnd());
      dsel = 3'(k);
      cyc(1);
      pwr = 1'b0;
      lwr = 1'b1;
      lsel = 3'(k);
      lval = seed[9];
      e8 = pval;
      e8[k] = lval;
      cyc(1);
      lwr = 1'b0;
      chk(32'(dout), 32'(e8));
      chk(32'(dport), 32'(din));
      chkb(dline, din[k]);
    end
    rd_en = 1'b1;
    scan(1'b1, 1'b0);
    scan(1'b0, 1'b1);
    rd_en = 1'b0;
    bank = 3'h6;
    en = '1;
    div = 16'h0006;
    pulse_start();
    for (int k = 0; k < 3000 && ovr !== 1'b1; k++) cyc(1);
    cyc(3);
    got_q = {};
    chkb(ovr, 1'b1);
    chkb(run, 1'b0);
    chk(32'(fill), 32'h0000_0100);
    rd_en = 1'b1;
    cyc(30);
    chk(32'(got_q.size()), 32'h0000_0000);
    pulse_start();
    cyc(2);
    chkb(ovr, 1'b0);
    stop = 1'b1;
    cyc(1);
    stop = 1'b0;
    trig = 1'b1;
    din = 8'h01;
    pulse_start();
    cyc(30);
    chkb(run, 1'b0);
    din = 8'h00;
    cyc(3);
    din = 8'h01;
    cyc(10);
    din = 8'h00;
    cyc(3);
    chkb(run, 1'b0);
    din = 8'h01;
    cyc(26);
    chkb(run, 1'b1);
    din = 8'h00;
    cyc(5);
    chkb(run, 1'b1);
    end_sim();
  end

  initial begin
    cyc(20000);
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire

// ---- verilog/msa_defines.svh ----
`ifndef MSA_DEFINES_SVH
`define MSA_DEFINES_SVH

`define MSA_NUM_CH_MAX 48
`define MSA_CH_IDX_W 6
`define MSA_BANK_CH 6'h08
`define MSA_BANK_MAX 3'h6
`define MSA_DIO_W 8
`define MSA_WORD_W 32
`define MSA_DIV_W 16
`define MSA_FIFO_AW 8
`define MSA_FIFO_DEPTH 9'h100
`define MSA_SYS_CLK_HZ 50000000
`define MSA_BASE_CLK_HZ 10
`define MSA_BASE_CYC (`MSA_SYS_CLK_HZ / `MSA_BASE_CLK_HZ)
`define MSA_TRIG_HOLD_MS 100
`define MSA_TRIG_HOLD_CYC ((`MSA_SYS_CLK_HZ / 1000) * `MSA_TRIG_HOLD_MS)
`define MSA_OPEN_WORD 32'h47C3_4F80
`define MSA_ABOVE_WORD 32'h47AD_9C00
`define MSA_BELOW_WORD 32'hC7AD_9C00
`define MSA_FLOAT_BIAS 8'h7F

`endif

// ---- verilog/msa_fifo_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msa_defines.svh"

module msa_fifo_mem (
  input wire logic i_sys_clk,
  input wire logic i_ce,
  input wire logic i_wr_en,
  input wire logic [`MSA_FIFO_AW-1:0] i_wr_addr,
  input wire logic [`MSA_WORD_W-1:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [`MSA_FIFO_AW-1:0] i_rd_addr,
  output logic [`MSA_WORD_W-1:0] o_rd_data
);

  logic [`MSA_WORD_W-1:0] mem [0:(1<<`MSA_FIFO_AW)-1];

  // read before write on the same address
  always_ff @(posedge i_sys_clk) begin
    if (i_ce) begin
      if (i_wr_en) begin
        mem[i_wr_addr] <= i_wr_data;
      end
      if (i_rd_en) begin
        o_rd_data <= mem[i_rd_addr];
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/msa_pkg.sv ----
`default_nettype none
`include "msa_defines.svh"

package msa_pkg;

  typedef enum logic [2:0] {
    MSA_IDLE      = 3'b000,
    MSA_WAIT_LOW  = 3'b001,
    MSA_WAIT_HIGH = 3'b010,
    MSA_RUN       = 3'b011,
    MSA_SCAN      = 3'b100,
    MSA_HALT      = 3'b101
  } msa_state_e;

  // one analog channel as the converter front end presents it
  typedef struct packed {
    logic open_sensor;
    logic above_range;
    logic below_range;
    logic [`MSA_WORD_W-1:0] value;
    logic [`MSA_WORD_W-1:0] cjc;
  } msa_chan_s;

  // one word handed to the host
  typedef struct packed {
    logic valid;
    logic [`MSA_WORD_W-1:0] data;
  } msa_rd_s;

endpackage
`default_nettype wire

// ---- verilog/msa_scan_acq.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msa_defines.svh"

module msa_scan_acq import msa_pkg::*; #(
  parameter int unsigned BASE_CYCLES = `MSA_BASE_CYC,
  parameter int unsigned TRIG_CYCLES = `MSA_TRIG_HOLD_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_ext_trig_en,
  input wire logic [`MSA_DIV_W-1:0] i_clk_div,
  input wire logic [2:0] i_bank_count,
  input wire logic [`MSA_NUM_CH_MAX:0] i_chan_en,
  input wire logic i_cjc_en,
  input wire logic i_filter_avg,
  input wire msa_chan_s i_chan [`MSA_NUM_CH_MAX],
  input wire logic [`MSA_DIO_W-1:0] i_din,
  input wire logic [2:0] i_din_line_sel,
  input wire logic i_dout_port_wr,
  input wire logic [`MSA_DIO_W-1:0] i_dout_port_val,
  input wire logic i_dout_line_wr,
  input wire logic [2:0] i_dout_line_sel,
  input wire logic i_dout_line_val,
  input wire logic i_rd_req,
  output logic [`MSA_DIO_W-1:0] o_dout,
  output logic o_dout_en,
  output logic [`MSA_DIO_W-1:0] o_din_port,
  output logic o_din_line,
  output logic o_filter_avg,
  output msa_rd_s o_rd,
  output logic o_running,
  output logic o_overrun,
  output logic o_overrun_evt,
  output logic [`MSA_FIFO_AW:0] o_fill
);

  // small unsigned byte to single precision
  function automatic logic [31:0] byte_to_float(input logic [7:0] v);
    int p;
    logic [22:0] m;
    logic [31:0] f;
    p = 0;
    f = '0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        p = i;
      end
    end
    m = 23'({15'h0000, v} << (23 - p));
    if (v != 8'h00) begin
      f = {1'b0, 8'(`MSA_FLOAT_BIAS + 8'(p)), m};
    end
    return f;
  endfunction

  msa_state_e state_reg, state_next;
  logic [`MSA_DIO_W-1:0] din_reg;
  logic [`MSA_DIO_W-1:0] din_snap_reg;
  msa_chan_s snap_reg [`MSA_NUM_CH_MAX];
  logic [`MSA_NUM_CH_MAX:0] chan_en_reg;
  logic cjc_en_reg;
  logic [`MSA_CH_IDX_W-1:0] nai_reg;
  logic [`MSA_CH_IDX_W-1:0] idx_reg;
  logic cjc_phase_reg;
  logic [31:0] hold_cnt_reg;
  logic [`MSA_FIFO_AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [`MSA_FIFO_AW:0] count_reg;
  logic rd_pend_reg;
  logic [`MSA_WORD_W-1:0] mem_q;
  logic tick;

  // scan bookkeeping
  wire [2:0] bank_lim = (i_bank_count == 3'h0) ? 3'h1 :
    (i_bank_count > `MSA_BANK_MAX) ? `MSA_BANK_MAX : i_bank_count;
  wire [`MSA_CH_IDX_W-1:0] nai_cfg = 6'(bank_lim) * `MSA_BANK_CH;
  wire is_din = (idx_reg == nai_reg);
  wire [`MSA_CH_IDX_W-1:0] ch_sel = is_din ? '0 : idx_reg;
  msa_chan_s cur;
  assign cur = snap_reg[ch_sel];
  wire scanning = (state_reg == MSA_SCAN);
  wire emit = scanning && chan_en_reg[idx_reg];
  wire want_cjc = emit && cjc_en_reg && !is_din && !cjc_phase_reg;
  wire scan_done = scanning && is_din && !want_cjc;

  // word selection, sentinels take priority over the measurement
  wire [`MSA_WORD_W-1:0] meas_word =
    cur.open_sensor ? `MSA_OPEN_WORD :
    cur.above_range ? `MSA_ABOVE_WORD :
    cur.below_range ? `MSA_BELOW_WORD :
    cur.value;
  wire [`MSA_WORD_W-1:0] word =
    is_din ? byte_to_float(din_snap_reg) :
    cjc_phase_reg ? cur.cjc : meas_word;

  // fifo pointers
  wire fifo_full = (count_reg == `MSA_FIFO_DEPTH);
  wire fifo_empty = (count_reg == '0);
  wire rd_take = i_rd_req && !fifo_empty && !rd_pend_reg && !o_overrun;
  wire over_write = emit && fifo_full && !rd_take;
  wire run_active = (state_reg == MSA_RUN) || scanning;
  wire start_go = i_start && ((state_reg == MSA_IDLE) ||
    (state_reg == MSA_HALT));
  wire trig_line = din_reg[0];
  wire trig_held = (hold_cnt_reg >= TRIG_CYCLES - 1);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MSA_IDLE, MSA_HALT: begin
        if (start_go) begin
          state_next = i_ext_trig_en ? MSA_WAIT_LOW : MSA_RUN;
        end
      end
      MSA_WAIT_LOW: begin
        if (!trig_line) begin
          state_next = MSA_WAIT_HIGH;
        end
      end
      MSA_WAIT_HIGH: begin
        if (trig_line && trig_held) begin
          state_next = MSA_RUN;
        end
      end
      MSA_RUN: begin
        if (tick) begin
          state_next = MSA_SCAN;
        end
      end
      MSA_SCAN: begin
        if (over_write) begin
          state_next = MSA_HALT;
        end else if (scan_done) begin
          state_next = MSA_RUN;
        end
      end
      default: begin
        state_next = MSA_IDLE;
      end
    endcase
    if (i_stop && !start_go) begin
      state_next = MSA_IDLE;
    end
  end

  msa_tick_gen #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_ce(i_ce),
    .i_enable(run_active),
    .i_div(i_clk_div),
    .o_tick(tick)
  );

  msa_fifo_mem u_mem (
    .i_sys_clk(i_sys_clk),
    .i_ce(i_ce),
    .i_wr_en(emit),
    .i_wr_addr(wr_ptr_reg),
    .i_wr_data(word),
    .i_rd_en(rd_take),
    .i_rd_addr(rd_ptr_reg),
    .o_rd_data(mem_q)
  );

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_reg <= MSA_IDLE;
      din_reg <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
      din_reg <= i_din;
    end
  end

  // trigger hold timer, only watched while waiting
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      hold_cnt_reg <= '0;
    end else if (i_ce) begin
      if (state_reg == MSA_WAIT_HIGH && trig_line && !trig_held) begin
        hold_cnt_reg <= hold_cnt_reg + 1'b1;
      end else if (state_reg != MSA_WAIT_HIGH || !trig_line) begin
        hold_cnt_reg <= '0;
      end
    end
  end

  // configuration latched at start
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      chan_en_reg <= '0;
      cjc_en_reg <= 1'b0;
      nai_reg <= `MSA_BANK_CH;
      o_filter_avg <= 1'b0;
    end else if (i_ce && start_go) begin
      chan_en_reg <= i_chan_en;
      cjc_en_reg <= i_cjc_en;
      nai_reg <= nai_cfg;
      o_filter_avg <= i_filter_avg;
    end
  end

  // simultaneous snapshot of every channel
  genvar g;
  generate
    for (g = 0; g < `MSA_NUM_CH_MAX; g++) begin : g_snap
      always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
          snap_reg[g] <= '0;
        end else if (i_ce && state_reg == MSA_RUN && tick) begin
          snap_reg[g] <= i_chan[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      din_snap_reg <= '0;
    end else if (i_ce && state_reg == MSA_RUN && tick) begin
      din_snap_reg <= din_reg;
    end
  end

  // channel walk, lowest to highest
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      idx_reg <= '0;
      cjc_phase_reg <= 1'b0;
    end else if (i_ce) begin
      if (!scanning) begin
        idx_reg <= '0;
        cjc_phase_reg <= 1'b0;
      end else if (want_cjc) begin
        cjc_phase_reg <= 1'b1;
      end else begin
        cjc_phase_reg <= 1'b0;
        idx_reg <= idx_reg + 1'b1;
      end
    end
  end

  // circular fifo state
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (i_ce) begin
      if (start_go) begin
        wr_ptr_reg <= '0;
        rd_ptr_reg <= '0;
        count_reg <= '0;
      end else begin
        if (emit) begin
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (rd_take || over_write) begin
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
        if (emit && !rd_take && !fifo_full) begin
          count_reg <= count_reg + 1'b1;
        end else if (rd_take && !emit) begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

  // overrun flag and event
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_overrun <= 1'b0;
      o_overrun_evt <= 1'b0;
    end else if (i_ce) begin
      o_overrun_evt <= over_write;
      if (over_write) begin
        o_overrun <= 1'b1;
      end else if (start_go) begin
        o_overrun <= 1'b0;
      end
    end
  end

  // host read path, two cycles from request to data
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      rd_pend_reg <= 1'b0;
      o_rd <= '0;
    end else if (i_ce) begin
      rd_pend_reg <= rd_take;
      o_rd.valid <= rd_pend_reg;
      if (rd_pend_reg) begin
        o_rd.data <= mem_q;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_running <= 1'b0;
      o_fill <= '0;
    end else if (i_ce) begin
      o_running <= run_active;
      o_fill <= count_reg;
    end
  end

  // digital input read back
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_din_port <= '0;
      o_din_line <= 1'b0;
    end else if (i_ce) begin
      o_din_port <= din_reg;
      o_din_line <= din_reg[i_din_line_sel];
    end
  end

  // latched digital outputs, disabled until first write
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_dout <= '0;
      o_dout_en <= 1'b0;
    end else if (i_ce) begin
      if (i_dout_port_wr) begin
        o_dout <= i_dout_port_val;
        o_dout_en <= 1'b1;
      end else if (i_dout_line_wr) begin
        o_dout[i_dout_line_sel] <= i_dout_line_val;
        o_dout_en <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ---- verilog/msa_tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msa_defines.svh"

module msa_tick_gen #(
  parameter int unsigned BASE_CYCLES = `MSA_BASE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire logic [`MSA_DIV_W-1:0] i_div,
  output logic o_tick
);

  logic [31:0] base_cnt_reg;
  logic [`MSA_DIV_W-1:0] div_cnt_reg;
  wire base_pulse = (base_cnt_reg == BASE_CYCLES - 1);
  wire [`MSA_DIV_W-1:0] div_last = (i_div == '0) ? '0 : i_div - 1'b1;
  wire div_pulse = base_pulse && (div_cnt_reg >= div_last);

  // 10 Hz base, then integer divide
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      base_cnt_reg <= '0;
      div_cnt_reg <= '0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      if (!i_enable) begin
        base_cnt_reg <= '0;
        div_cnt_reg <= '0;
        o_tick <= 1'b0;
      end else begin
        base_cnt_reg <= base_pulse ? '0 : base_cnt_reg + 1'b1;
        if (base_pulse) begin
          div_cnt_reg <= div_pulse ? '0 : div_cnt_reg + 1'b1;
        end
        o_tick <= div_pulse;
      end
    end
  end

endmodule
`default_nettype wire
